//--- bench/wk_wakeup_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module wk_wakeup_timer_checker
   import wk_pkg::*;
(
   input wire logic       I_REF_CLK,      // Clock
   input wire logic       I_RSTN,         // Reset, low
   input wire logic       I_RD,           // Read strobe
   input wire logic       I_WAKE_EN,      // Timer enable
   input wire logic       I_SET_DEFAULT,  // Set-default pulse
   input wire logic       I_AMP_DONE,     // Amplitude done
   input wire logic       I_PH_DONE,      // Phase done
   input wire logic [7:0] O_RDATA,        // Read data
   input wire logic       O_AMP_MEAS_REQ, // Amplitude request
   input wire logic       O_PH_MEAS_REQ,  // Phase request
   input wire logic       O_IRQ_TIMEOUT,  // Expiry interrupt
   input wire logic       O_IRQ_AMP,      // Amplitude interrupt
   input wire logic       O_IRQ_PH        // Phase interrupt
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RSTN);

   chk_rd_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data outside its slot");
   chk_tmo_period: assert property (O_IRQ_TIMEOUT |=> !O_IRQ_TIMEOUT [*2])
      else $error("expiry pulses too close");
   chk_amp_req_pulse: assert property (O_AMP_MEAS_REQ |=> !O_AMP_MEAS_REQ)
      else $error("amplitude request longer than one cycle");
   chk_ph_req_pulse: assert property ($rose(O_PH_MEAS_REQ) |=> $fell(O_PH_MEAS_REQ))
      else $error("phase request longer than one cycle");
   chk_amp_irq_cause: assert property (O_IRQ_AMP |-> $past(I_AMP_DONE))
      else $error("amplitude interrupt without a result");
   chk_ph_irq_cause: assert property (O_IRQ_PH |-> $past(I_PH_DONE))
      else $error("phase interrupt without a result");
   chk_setdef_quiet: assert property (I_SET_DEFAULT |=> !(O_IRQ_TIMEOUT || O_IRQ_AMP || O_IRQ_PH))
      else $error("pulse after set-default");
   chk_wake_off: assert property (!I_WAKE_EN [*2] |=> !O_IRQ_TIMEOUT && !O_AMP_MEAS_REQ)
      else $error("timer ran while disabled");

   cov_amp_irq: cover property (O_IRQ_AMP);
   cov_ph_irq: cover property (O_IRQ_PH);
   cov_period: cover property (O_IRQ_TIMEOUT ##3 O_IRQ_TIMEOUT);
endmodule
`default_nettype wire

//--- bench/wk_wakeup_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wk_wakeup_timer_tb
   import wk_pkg::*;
;
   localparam int LONG  = 10;
   localparam int SHORT = 3;
   logic       clk, rstn, wr_en, rd_en, wake, setd, adone, pdone;
   logic       amp_req, ph_req, irq_t, irq_a, irq_p;
   logic [5:0] addr;
   logic [7:0] wdata, aval, pval, rdata, v;
   int         err_total, n_checks, n;

   wk_wakeup_timer #(.STEP_LONG_CYC_P(LONG), .STEP_SHORT_CYC_P(SHORT)) u_dut (
      .I_REF_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_en),
      .I_RD(rd_en), .O_RDATA(rdata), .I_WAKE_EN(wake), .I_SET_DEFAULT(setd),
      .I_AMP_DONE(adone), .I_AMP_VALUE(aval), .I_PH_DONE(pdone), .I_PH_VALUE(pval),
      .O_AMP_MEAS_REQ(amp_req), .O_PH_MEAS_REQ(ph_req), .O_IRQ_TIMEOUT(irq_t),
      .O_IRQ_AMP(irq_a), .O_IRQ_PH(irq_p));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic bus_rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic setdef();
      @(posedge clk);
      setd <= 1'b1;
      @(posedge clk);
      setd <= 1'b0;
   endtask

   // Waits for expiry (0), amplitude request (1) or phase request (2)
   task automatic wait_hi(input int sel);
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         #1;
         k++;
         if (k > 400)
         begin
            err_total++;
            summarize();
         end
      end
      while (!((sel == 0) ? irq_t : (sel == 1) ? amp_req : ph_req));
   endtask

   task automatic meas(input int ch, input logic [7:0] val, input logic exp_irq);
      wait_hi(ch + 1);
      // Measurement scenarios keep the periodic bit clear
      check({7'h00, irq_t}, 8'h00);
      @(posedge clk);
      adone <= (ch == 0);
      pdone <= (ch == 1);
      aval  <= val;
      pval  <= val;
      @(posedge clk);
      adone <= 1'b0;
      pdone <= 1'b0;
      #1;
      check({7'h00, (ch == 0) ? irq_a : irq_p}, {7'h00, exp_irq});
   endtask

   task automatic t_regs();
      logic [5:0] a;
      logic [7:0] e;
      for (int i = 'h30; i <= 'h3A; i++)
      begin
         a = i[5:0];
         bus_rd(a, v);
         check(v, 8'h00);
         bus_wr(a, 8'hA5);
         bus_rd(a, v);
         e = (a inside {ADDR_AMP_AVG, ADDR_AMP_RES, ADDR_PH_AVG, ADDR_PH_RES} || i < 'h31 || i > 'h39) ? 8'h00 :
             (a == ADDR_TIMER_CTRL) ? (8'hA5 & TMR_RSVD_MASK) : 8'hA5;
         check(v, e);
      end
      setdef();
      for (int i = 'h31; i <= 'h39; i++)
      begin
         bus_rd(i[5:0], v);
         check(v, 8'h00);
      end
   endtask

   task automatic t_timer();
      @(posedge clk);
      wake <= 1'b1;
      for (int r = 0; r < 2; r++)
         for (int c = 0; c < 8; c += 7)
         begin
            setdef();
            bus_wr(ADDR_TIMER_CTRL, {r[0], c[2:0], 4'hE});
            wait_hi(0);
            check({7'h00, amp_req & ph_req}, 8'h01);
            n = 0;
            do
            begin
               @(posedge clk);
               #1;
               n++;
            end
            while (!irq_t && n < 200);
            check(n[7:0], 8'((c + 1) * (r ? SHORT : LONG)));
         end
   endtask

   task automatic t_amp();
      setdef();
      bus_wr(ADDR_AMP_CFG, 8'h20);
      bus_wr(ADDR_AMP_REF, 8'h10);
      // Long range keeps the next request clear of the bus accesses between measurements
      bus_wr(ADDR_TIMER_CTRL, 8'h04);
      meas(0, 8'h40, 1'b1);
      bus_rd(ADDR_AMP_RES, v);
      check(v, 8'h40);
      bus_rd(ADDR_AMP_AVG, v);
      check(v, 8'h00);
      meas(0, 8'h12, 1'b0);
      bus_rd(ADDR_AMP_AVG, v);
      check(v, 8'h04);
      bus_wr(ADDR_AMP_CFG, 8'h29);
      meas(0, 8'h40, 1'b1);
      bus_rd(ADDR_AMP_AVG, v);
      check(v, 8'h13);
   endtask

   task automatic t_phase();
      for (int w = 0; w < 4; w++)
      begin
         setdef();
         bus_wr(ADDR_PH_CFG, {4'hF, 1'b0, w[1:0], 1'b0});
         bus_wr(ADDR_PH_REF, 8'h80);
         bus_wr(ADDR_TIMER_CTRL, 8'h02);
         meas(1, 8'h80, 1'b0);
         bus_rd(ADDR_PH_AVG, v);
         check(v, 8'h80 >> (2 + w));
         bus_wr(ADDR_PH_CFG, {4'h0, 1'b0, w[1:0], 1'b1});
         meas(1, v, 1'b0);
         meas(1, 8'h00, 1'b1);
         bus_rd(ADDR_PH_AVG, v);
         check(v, 8'h80 >> (2 + w));
      end
   endtask

   initial
   begin
      {rstn, wr_en, rd_en, wake, setd, adone, pdone} = '0;
      {addr, wdata, aval, pval} = '0;
      err_total = 0;
      n_checks = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_timer();
      t_amp();
      t_phase();
      summarize();
   end
endmodule

bind wk_wakeup_timer wk_wakeup_timer_checker u_chk (
   .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_RD(I_RD), .I_WAKE_EN(I_WAKE_EN),
   .I_SET_DEFAULT(I_SET_DEFAULT), .I_AMP_DONE(I_AMP_DONE), .I_PH_DONE(I_PH_DONE),
   .O_RDATA(O_RDATA), .O_AMP_MEAS_REQ(O_AMP_MEAS_REQ), .O_PH_MEAS_REQ(O_PH_MEAS_REQ),
   .O_IRQ_TIMEOUT(O_IRQ_TIMEOUT), .O_IRQ_AMP(O_IRQ_AMP), .O_IRQ_PH(O_IRQ_PH));
`default_nettype wire

//--- hw/wk_pkg.sv
// How it works
// R1: Range bit picks the timer step: 0 gives 100 ms, 1 gives 10 ms.
// R2: Timeout equals the three-bit code plus one, times the selected step.
// R3: Periodic bit set raises an interrupt pulse at every timer expiry.
// R4: Amplitude check bit set requests an amplitude measurement at each expiry where no amplitude measurement is pending.
// R5: Phase check bit set requests a phase measurement at each expiry where no phase measurement is pending.
// R6: Amplitude threshold sits in config bits 7:4; larger difference raises an interrupt.
// R7: Amplitude include bit decides whether an interrupting measurement enters the average.
// R8: Two-bit weight code selects averaging weight 4, 8, 16 or 32.
// R9: Amplitude source bit picks software reference (0) or running average (1).
// R10: Eight-bit read-write amplitude reference register.
// R11: Eight-bit read-only amplitude running average register.
// R12: Eight-bit read-only amplitude result register.
// R13: Phase threshold sits in config bits 7:4; larger difference raises an interrupt.
// R14: Phase include bit decides whether an interrupting measurement enters the average.
// R15: Phase source bit picks software reference (0) or running average (1).
// R16: All configuration fields clear at reset and on the set-default command.
// R17: Result and average registers clear at reset and on set-default.
// R18: Eight-bit read-write phase reference register.
// R19: Eight-bit read-only phase running average register.
// R20: New average is old average plus difference divided by the weight.
// R21: Timer restarts after every expiry while wake-up operation is enabled.
package wk_pkg;

   localparam logic [5:0] ADDR_TIMER_CTRL = 6'h31;
   localparam logic [5:0] ADDR_AMP_CFG    = 6'h32;
   localparam logic [5:0] ADDR_AMP_REF    = 6'h33;
   localparam logic [5:0] ADDR_AMP_AVG    = 6'h34;
   localparam logic [5:0] ADDR_AMP_RES    = 6'h35;
   localparam logic [5:0] ADDR_PH_CFG     = 6'h36;
   localparam logic [5:0] ADDR_PH_REF     = 6'h37;
   localparam logic [5:0] ADDR_PH_AVG     = 6'h38;
   localparam logic [5:0] ADDR_PH_RES     = 6'h39;

   // Field positions of the timer control and both check configurations
   localparam int TMR_RANGE_BIT    = 7;
   localparam int TMR_CODE_LSB     = 4;
   localparam int TMR_PERIODIC_BIT = 3;
   localparam int TMR_AMP_BIT      = 2;
   localparam int TMR_PH_BIT       = 1;
   localparam int CHK_THR_LSB      = 4;
   localparam int CHK_INCL_BIT     = 3;
   localparam int CHK_WGT_LSB      = 1;
   localparam int CHK_SRC_BIT      = 0;

   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic [7:0] TMR_RSVD_MASK   = 8'hFE;
   localparam logic [2:0] WGT_SHIFT_BASE  = 3'h2;

   localparam int PRESC_W       = 23;
   localparam int CLK_HZ        = 40_000_000;
   localparam int STEP_LONG_MS  = 100;
   localparam int STEP_SHORT_MS = 10;
   localparam int STEP_LONG_CYC  = STEP_LONG_MS * (CLK_HZ / 1000);
   localparam int STEP_SHORT_CYC = STEP_SHORT_MS * (CLK_HZ / 1000);

   typedef struct packed {
      logic       range;
      logic [2:0] code;
      logic       periodic;
      logic       amp_chk;
      logic       ph_chk;
      logic       rsvd;
   } wk_tmr_cfg_s;

   typedef struct packed {
      logic [3:0] thr;
      logic       incl;
      logic [1:0] wgt;
      logic       src;
   } wk_chk_cfg_s;

   typedef struct packed {
      logic [7:0] ref_val;
      logic [7:0] avg;
      logic [7:0] result;
      logic       busy;
   } wk_chan_s;

   typedef struct packed {
      logic       done;
      logic [7:0] value;
   } wk_meas_s;

   typedef struct packed {
      wk_tmr_cfg_s          tmr;
      wk_chk_cfg_s          amp_cfg;
      wk_chk_cfg_s          ph_cfg;
      wk_chan_s             amp;
      wk_chan_s             ph;
      logic [PRESC_W-1:0]   presc;
      logic [2:0]           steps;
      logic [7:0]           rdata;
      logic                 amp_req;
      logic                 ph_req;
      logic                 irq_tmo;
      logic                 irq_amp;
      logic                 irq_ph;
   } wk_state_s;

endpackage

//--- hw/wk_wakeup_timer.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module wk_wakeup_timer
   import wk_pkg::*;
#(
   parameter int unsigned STEP_LONG_CYC_P  = STEP_LONG_CYC,
   parameter int unsigned STEP_SHORT_CYC_P = STEP_SHORT_CYC
)
(
   input  wire logic       I_REF_CLK,         // 40 MHz clock
   input  wire logic       I_RSTN,            // Async reset, low
   input  wire logic [5:0] I_ADDR,            // Register address
   input  wire logic [7:0] I_WDATA,           // Write data
   input  wire logic       I_WR,              // Write strobe
   input  wire logic       I_RD,              // Read strobe
   output logic      [7:0] O_RDATA,           // Read data, cycle after read
   input  wire logic       I_WAKE_EN,         // Wake-up operation enable
   input  wire logic       I_SET_DEFAULT,     // Set-default command pulse
   input  wire logic       I_AMP_DONE,        // Amplitude result valid
   input  wire logic [7:0] I_AMP_VALUE,       // Amplitude result
   input  wire logic       I_PH_DONE,         // Phase result valid
   input  wire logic [7:0] I_PH_VALUE,        // Phase result
   output logic            O_AMP_MEAS_REQ,    // Start amplitude measurement
   output logic            O_PH_MEAS_REQ,     // Start phase measurement
   output logic            O_IRQ_TIMEOUT,     // Timer expiry interrupt
   output logic            O_IRQ_AMP,         // Amplitude deviation interrupt
   output logic            O_IRQ_PH           // Phase deviation interrupt
);

   localparam logic [PRESC_W-1:0] LONG_LAST  = PRESC_W'(STEP_LONG_CYC_P - 1);
   localparam logic [PRESC_W-1:0] SHORT_LAST = PRESC_W'(STEP_SHORT_CYC_P - 1);

   wk_state_s s;
   wk_state_s next_s;
   wk_meas_s  amp_in;
   wk_meas_s  ph_in;

   assign amp_in = '{done: I_AMP_DONE, value: I_AMP_VALUE};
   assign ph_in  = '{done: I_PH_DONE, value: I_PH_VALUE};

   // Absolute difference against the threshold, strictly greater
   function automatic logic chk_hit
   (
      input logic [7:0] meas,
      input logic [7:0] ref_val,
      input logic [3:0] thr
   );
      logic [7:0] diff;
      diff = (meas >= ref_val) ? (meas - ref_val) : (ref_val - meas);
      return diff > {4'h0, thr};
   endfunction

   // Average moves by the difference divided by 4, 8, 16 or 32
   function automatic logic [7:0] avg_next
   (
      input logic [7:0] avg,
      input logic [7:0] meas,
      input logic [1:0] wgt
   );
      logic signed [9:0] diff;
      logic signed [9:0] step;
      logic        [2:0] sh;
      logic        [9:0] sum;
      diff = $signed({2'h0, meas}) - $signed({2'h0, avg});
      sh   = {1'b0, wgt} + WGT_SHIFT_BASE;                   // R8
      step = diff >>> sh;                                    // R20
      sum  = {2'h0, avg} + $unsigned(step);
      return sum[7:0];
   endfunction

   // Reference selected by the source bit
   function automatic logic chan_hit
   (
      input wk_chan_s    c,
      input wk_chk_cfg_s cfg,
      input logic [7:0]  meas
   );
      logic [7:0] ref_sel;
      ref_sel = cfg.src ? c.avg : c.ref_val;                 // R9 R15
      return chk_hit(meas, ref_sel, cfg.thr);                // R6 R13
   endfunction

   // Store a finished measurement and update the running average
   function automatic wk_chan_s chan_take
   (
      input wk_chan_s    c,
      input wk_chk_cfg_s cfg,
      input logic [7:0]  meas,
      input logic        hit
   );
      wk_chan_s r;
      r        = c;
      r.result = meas;                                       // R12
      if (!hit || cfg.incl)                                  // R7 R14
      begin
         r.avg = avg_next(c.avg, meas, cfg.wgt);             // R20
      end
      r.busy = 1'b0;
      return r;
   endfunction

   always_comb
   begin
      logic [PRESC_W-1:0] step_last;
      logic               expire;
      logic               restart;
      logic               wr_tmr;
      logic               amp_hit;
      logic               ph_hit;
      next_s  = s;
      step_last = s.tmr.range ? SHORT_LAST : LONG_LAST;     // R1
      expire  = 1'b0;
      amp_hit = 1'b0;
      ph_hit  = 1'b0;
      wr_tmr  = I_WR && (I_ADDR == ADDR_TIMER_CTRL);
      restart = wr_tmr || I_SET_DEFAULT;

      next_s.amp_req = 1'b0;
      next_s.ph_req  = 1'b0;
      next_s.irq_tmo = 1'b0;
      next_s.irq_amp = 1'b0;
      next_s.irq_ph  = 1'b0;

      // Wake-up timer; a new timer setting starts a fresh period
      if (!I_WAKE_EN || restart)
      begin
         next_s.presc = '0;
         next_s.steps = 3'h0;
      end
      else if (s.presc == step_last)
      begin
         next_s.presc = '0;
         if (s.steps == s.tmr.code)                          // R2
         begin
            next_s.steps = 3'h0;                             // R21
            expire       = 1'b1;
         end
         else
         begin
            next_s.steps = s.steps + 3'h1;
         end
      end
      else
      begin
         next_s.presc = s.presc + PRESC_W'(1);
      end

      // Actions at expiry
      if (expire)
      begin
         next_s.irq_tmo = s.tmr.periodic;                    // R3
         if (s.tmr.amp_chk && !s.amp.busy)                   // R4
         begin
            next_s.amp_req  = 1'b1;
            next_s.amp.busy = 1'b1;
         end
         if (s.tmr.ph_chk && !s.ph.busy)                     // R5
         begin
            next_s.ph_req  = 1'b1;
            next_s.ph.busy = 1'b1;
         end
      end

      // Register writes; read-only views ignore writes
      if (I_WR)
      begin
         unique case (I_ADDR)
            ADDR_TIMER_CTRL:
            begin
               next_s.tmr = wk_tmr_cfg_s'(I_WDATA & TMR_RSVD_MASK);
            end
            ADDR_AMP_CFG:
            begin
               next_s.amp_cfg = wk_chk_cfg_s'(I_WDATA);
            end
            ADDR_AMP_REF:
            begin
               next_s.amp.ref_val = I_WDATA;                 // R10
            end
            ADDR_PH_CFG:
            begin
               next_s.ph_cfg = wk_chk_cfg_s'(I_WDATA);
            end
            ADDR_PH_REF:
            begin
               next_s.ph.ref_val = I_WDATA;                  // R18
            end
            default:
            begin
            end
         endcase
      end

      // Finished measurements, taken only while one is pending
      // Interrupt and averaging share one decision, made on the reference before any write this cycle
      if (amp_in.done && s.amp.busy)
      begin
         amp_hit        = chan_hit(s.amp, s.amp_cfg, amp_in.value);
         next_s.amp     = chan_take(next_s.amp, s.amp_cfg, amp_in.value, amp_hit);
         next_s.irq_amp = amp_hit;                           // R6
      end
      if (ph_in.done && s.ph.busy)
      begin
         ph_hit        = chan_hit(s.ph, s.ph_cfg, ph_in.value);
         next_s.ph     = chan_take(next_s.ph, s.ph_cfg, ph_in.value, ph_hit);
         next_s.irq_ph = ph_hit;                             // R13
      end

      // Read data stand one cycle, zero otherwise
      next_s.rdata = 8'h00;
      if (I_RD)
      begin
         unique case (I_ADDR)
            ADDR_TIMER_CTRL:
            begin
               next_s.rdata = s.tmr;
            end
            ADDR_AMP_CFG:
            begin
               next_s.rdata = s.amp_cfg;
            end
            ADDR_AMP_REF:
            begin
               next_s.rdata = s.amp.ref_val;                 // R10
            end
            ADDR_AMP_AVG:
            begin
               next_s.rdata = s.amp.avg;                     // R11
            end
            ADDR_AMP_RES:
            begin
               next_s.rdata = s.amp.result;                  // R12
            end
            ADDR_PH_CFG:
            begin
               next_s.rdata = s.ph_cfg;
            end
            ADDR_PH_REF:
            begin
               next_s.rdata = s.ph.ref_val;                  // R18
            end
            ADDR_PH_AVG:
            begin
               next_s.rdata = s.ph.avg;                      // R19
            end
            ADDR_PH_RES:
            begin
               next_s.rdata = s.ph.result;
            end
            default:
            begin
               next_s.rdata = REG_RESET;
            end
         endcase
      end

      // Set-default clears everything it owns and drops pending work
      if (I_SET_DEFAULT)
      begin
         next_s.tmr     = wk_tmr_cfg_s'(REG_RESET);          // R16
         next_s.amp_cfg = wk_chk_cfg_s'(REG_RESET);          // R16
         next_s.ph_cfg  = wk_chk_cfg_s'(REG_RESET);          // R16
         next_s.amp     = '0;                                // R16 R17
         next_s.ph      = '0;                                // R16 R17
         next_s.amp_req = 1'b0;
         next_s.ph_req  = 1'b0;
         next_s.irq_tmo = 1'b0;
         next_s.irq_amp = 1'b0;
         next_s.irq_ph  = 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         s <= '0;                                            // R16 R17
      end
      else
      begin
         s <= next_s;
      end
   end

   assign O_RDATA        = s.rdata;
   assign O_AMP_MEAS_REQ = s.amp_req;
   assign O_PH_MEAS_REQ  = s.ph_req;
   assign O_IRQ_TIMEOUT  = s.irq_tmo;
   assign O_IRQ_AMP      = s.irq_amp;
   assign O_IRQ_PH       = s.irq_ph;

endmodule
`default_nettype wire
